/* File: verilog/fbh_ctrl.sv */
// module: host controller driving a parallel flash bus, AHB-Lite registers
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// [R1] device aborts busy work within 35 us reset
// [R2] idle device returns to read within 500 ns
// [R3] wait 50 ns after reset release before read
// [R4] standby only after 35 us reset low
// [R5] narrow width floats upper outputs within 16 ns
// [R6] full width drives data within 60/70 ns
// [R7] program takes about 6 us
// [R8] sector erase takes about 0.4 s
// [R9] ready/busy goes busy shortly after command
// [R10] new write allowed as soon as ready
// [R11] write may follow read with no gap
// [R12] suspend toggle only in suspended sector
// [R13] either chip select or output enable strobes polls
// [R14] general toggle independent of read address
// [R15] poll until reads return array data
// [R16] programmed location reads back written data
// [R17] poll bit reads complement during program
// [R18] erase first preprograms target to 00h
// [R19] ready/busy busy for whole internal sequence
// [R20] general toggle stops once operation completes
module fbh_ctrl (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output var  logic        hreadyout,
  output var  logic        hresp,
  output var  logic [31:0] hrdata,
  output var  logic [21:0] f_addr,
  input  wire logic [15:0] f_dq_i,
  output var  logic [15:0] f_dq_o,
  output var  logic        f_dq_oe,
  output var  logic        f_ce_n,
  output var  logic        f_oe_n,
  output var  logic        f_we_n,
  output var  logic        f_reset_n,
  output var  logic        f_word_n_byte,
  input  wire logic        ready_busy_flag
);
  // ==========================================================
  // state
  fbh_pkg::fbh_state_t state_r, state_nxt;
  logic [7:0]  cnt_r, cnt_nxt;
  logic        wr_pend_r, wr_pend_nxt;
  logic [4:0]  wr_ofs_r, wr_ofs_nxt;
  logic [1:0]  cfg_r, cfg_nxt;
  logic [21:0] addr_r, addr_nxt;
  logic [15:0] wdata_r, wdata_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic        poll_r, poll_nxt;
  logic        have_prev_r, have_prev_nxt;
  logic        done_r, done_nxt;
  logic        rb_r, rb_nxt;
  logic [31:0] hrdata_nxt;
  logic [21:0] f_addr_nxt;
  logic [15:0] f_dq_o_nxt;
  logic        f_dq_oe_nxt, f_ce_n_nxt, f_oe_n_nxt, f_we_n_nxt, f_reset_n_nxt;
  logic        a_phase, cmd_go;
  logic [1:0]  cmd_op;

  assign a_phase = hsel && htrans[1] && hready;
  assign cmd_go  = wr_pend_r && (wr_ofs_r == fbh_pkg::OFS_CMD) && (state_r == fbh_pkg::ST_IDLE);
  assign cmd_op  = hwdata[fbh_pkg::CMD_OP_LSB +: 2];

  // ==========================================================
  // next values
  always_comb begin
    state_nxt     = state_r;
    cnt_nxt       = (cnt_r != 8'h00) ? cnt_r - 8'h01 : 8'h00;
    wr_pend_nxt   = a_phase && hwrite && (haddr[31:5] == 27'h0);
    wr_ofs_nxt    = haddr[4:0];
    cfg_nxt       = cfg_r;
    addr_nxt      = addr_r;
    wdata_nxt     = wdata_r;
    rdata_nxt     = rdata_r;
    poll_nxt      = poll_r;
    have_prev_nxt = have_prev_r;
    done_nxt      = done_r;
    rb_nxt        = ready_busy_flag;
    f_addr_nxt    = f_addr;
    f_dq_o_nxt    = f_dq_o;
    f_dq_oe_nxt   = f_dq_oe;
    f_ce_n_nxt    = f_ce_n;
    f_oe_n_nxt    = f_oe_n;
    f_we_n_nxt    = f_we_n;
    f_reset_n_nxt = f_reset_n;
    hrdata_nxt    = 32'h00000000;
    // register reads, answered in the data phase
    if (a_phase && !hwrite) begin
      if (fbh_pkg::fbh_hit(haddr, fbh_pkg::OFS_CFG))    hrdata_nxt = {30'h0, cfg_r};
      if (fbh_pkg::fbh_hit(haddr, fbh_pkg::OFS_ADDR))   hrdata_nxt = {10'h000, addr_r};
      if (fbh_pkg::fbh_hit(haddr, fbh_pkg::OFS_WDATA))  hrdata_nxt = {16'h0000, wdata_r};
      if (fbh_pkg::fbh_hit(haddr, fbh_pkg::OFS_RDATA))  hrdata_nxt = {16'h0000, rdata_r};
      if (fbh_pkg::fbh_hit(haddr, fbh_pkg::OFS_STATUS)) begin
        hrdata_nxt = {29'h0, rb_r, done_r, state_r != fbh_pkg::ST_IDLE};
      end
    end
    // register writes, data phase
    if (wr_pend_r) begin
      if (wr_ofs_r == fbh_pkg::OFS_CFG)   cfg_nxt = hwdata[1:0];
      if (wr_ofs_r == fbh_pkg::OFS_ADDR)  addr_nxt = hwdata[21:0];
      if (wr_ofs_r == fbh_pkg::OFS_WDATA) wdata_nxt = hwdata[15:0];
    end
    case (state_r)
      fbh_pkg::ST_IDLE: begin
        if (cmd_go && cmd_op != 2'h0) begin
          done_nxt      = 1'b0;
          poll_nxt      = hwdata[fbh_pkg::CMD_POLL];
          have_prev_nxt = 1'b0;
          f_addr_nxt    = addr_r;
          case (cmd_op)
            fbh_pkg::OP_WRITE: begin
              // no wait on ready/busy or after a read
              state_nxt   = fbh_pkg::ST_WR; // [R10] [R11]
              cnt_nxt     = fbh_pkg::WP_CYC - 8'h01;
              f_dq_o_nxt  = wdata_r;
              f_dq_oe_nxt = 1'b1;
              f_ce_n_nxt  = 1'b0;
              f_we_n_nxt  = 1'b0;
            end
            fbh_pkg::OP_READ: begin
              state_nxt  = fbh_pkg::ST_RD;
              cnt_nxt    = fbh_pkg::ACC_CYC - 8'h01;
              f_ce_n_nxt = 1'b0;
              f_oe_n_nxt = 1'b0;
            end
            default: begin
              state_nxt     = fbh_pkg::ST_RST;
              cnt_nxt       = fbh_pkg::RP_CYC - 8'h01;
              f_reset_n_nxt = 1'b0;
            end
          endcase
        end
      end
      fbh_pkg::ST_WR: begin
        if (cnt_r == 8'h00) begin
          state_nxt   = fbh_pkg::ST_GAP;
          cnt_nxt     = fbh_pkg::WPH_CYC - 8'h01;
          f_we_n_nxt  = 1'b1;
          f_ce_n_nxt  = 1'b1;
          f_dq_oe_nxt = 1'b0;
          poll_nxt    = 1'b0;
        end
      end
      fbh_pkg::ST_RD: begin
        if (cnt_r == 8'h00) begin
          rdata_nxt     = f_dq_i;
          have_prev_nxt = 1'b1;
          // end the strobe on both lines; a poll is done once the bit stops
          f_oe_n_nxt    = 1'b1; // [R13]
          f_ce_n_nxt    = 1'b1; // [R13]
          state_nxt     = fbh_pkg::ST_GAP;
          cnt_nxt       = fbh_pkg::OEPH_CYC - 8'h01;
          if (!(poll_r && (!have_prev_r ||
              (f_dq_i[fbh_pkg::GEN_TOG_BIT] != rdata_r[fbh_pkg::GEN_TOG_BIT])))) begin
            poll_nxt = 1'b0; // [R15]
          end
        end
      end
      fbh_pkg::ST_GAP: begin
        if (cnt_r == 8'h00) begin
          if (poll_r) begin
            // the selected strobe toggles; the other goes high with it for the first gap cycle only
            state_nxt  = fbh_pkg::ST_RD;
            cnt_nxt    = fbh_pkg::ACC_CYC - 8'h01;
            f_ce_n_nxt = 1'b0; // [R13]
            f_oe_n_nxt = 1'b0; // [R13]
          end else begin
            state_nxt = fbh_pkg::ST_IDLE;
            done_nxt  = 1'b1;
          end
        end else if (poll_r) begin
          if (cfg_r[fbh_pkg::CFG_CE_STB]) f_oe_n_nxt = 1'b0; // [R13]
          else                            f_ce_n_nxt = 1'b0; // [R13]
        end
      end
      fbh_pkg::ST_RST: begin
        if (cnt_r == 8'h00) begin
          state_nxt     = fbh_pkg::ST_RREC;
          cnt_nxt       = fbh_pkg::RH_CYC - 8'h01;
          f_reset_n_nxt = 1'b1;
        end
      end
      fbh_pkg::ST_RREC: begin
        if (cnt_r == 8'h00) begin
          state_nxt = fbh_pkg::ST_IDLE; // [R3]
          done_nxt  = 1'b1;
        end
      end
      default: state_nxt = fbh_pkg::ST_IDLE;
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r       <= fbh_pkg::ST_IDLE;
      cnt_r         <= 8'h00;
      wr_pend_r     <= 1'b0;
      wr_ofs_r      <= 5'h00;
      cfg_r         <= fbh_pkg::CFG_RST;
      addr_r        <= 22'h000000;
      wdata_r       <= 16'h0000;
      rdata_r       <= 16'h0000;
      poll_r        <= 1'b0;
      have_prev_r   <= 1'b0;
      done_r        <= 1'b0;
      rb_r          <= 1'b0;
      hreadyout     <= 1'b1;
      hresp         <= 1'b0;
      hrdata        <= 32'h00000000;
      f_addr        <= 22'h000000;
      f_dq_o        <= 16'h0000;
      f_dq_oe       <= 1'b0;
      f_ce_n        <= 1'b1;
      f_oe_n        <= 1'b1;
      f_we_n        <= 1'b1;
      f_reset_n     <= 1'b1;
      f_word_n_byte <= 1'b1;
    end else begin
      state_r       <= state_nxt;
      cnt_r         <= cnt_nxt;
      wr_pend_r     <= wr_pend_nxt;
      wr_ofs_r      <= wr_ofs_nxt;
      cfg_r         <= cfg_nxt;
      addr_r        <= addr_nxt;
      wdata_r       <= wdata_nxt;
      rdata_r       <= rdata_nxt;
      poll_r        <= poll_nxt;
      have_prev_r   <= have_prev_nxt;
      done_r        <= done_nxt;
      rb_r          <= rb_nxt;
      hreadyout     <= 1'b1;
      hresp         <= 1'b0;
      hrdata        <= hrdata_nxt;
      f_addr        <= f_addr_nxt;
      f_dq_o        <= f_dq_o_nxt;
      f_dq_oe       <= f_dq_oe_nxt;
      f_ce_n        <= f_ce_n_nxt;
      f_oe_n        <= f_oe_n_nxt;
      f_we_n        <= f_we_n_nxt;
      f_reset_n     <= f_reset_n_nxt;
      f_word_n_byte <= cfg_r[fbh_pkg::CFG_WORD];
    end
  end

  // ==========================================================
  // checks
  logic [7:0]  since_rel_r;
  logic [15:0] prev_samp_r;
  logic        poll_cmd_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      since_rel_r <= 8'hff;
      prev_samp_r <= 16'h0000;
      poll_cmd_r  <= 1'b0;
    end else begin
      if (cmd_go && cmd_op != 2'h0) begin
        poll_cmd_r <= (cmd_op == fbh_pkg::OP_READ) && hwdata[fbh_pkg::CMD_POLL];
      end
      if (!f_reset_n) since_rel_r <= 8'h00;
      else if (since_rel_r != 8'hff) since_rel_r <= since_rel_r + 8'h01;
      if (state_r == fbh_pkg::ST_RD && cnt_r == 8'h00) prev_samp_r <= rdata_r;
    end
  end

  a_reset_read_gap: assert property (@(posedge hclk) disable iff (!hresetn) // [R3]
    $fell(f_oe_n) |-> since_rel_r >= fbh_pkg::RH_CYC)
    else $error("read started too soon after reset release");
  a_write_no_wait: assert property (@(posedge hclk) disable iff (!hresetn) // [R10]
    (cmd_go && cmd_op == fbh_pkg::OP_WRITE) |=> (!f_we_n && !f_ce_n) [*8] ##1 f_we_n)
    else $error("write strobe not issued at once or wrong width");
  a_read_then_write: assert property (@(posedge hclk) disable iff (!hresetn) // [R11]
    (state_r == fbh_pkg::ST_GAP && !poll_r && cnt_r == 8'h00) |=> state_r == fbh_pkg::ST_IDLE)
    else $error("extra recovery inserted before next access");
  a_poll_strobe: assert property (@(posedge hclk) disable iff (!hresetn) // [R13]
    (state_r == fbh_pkg::ST_GAP && poll_r && cnt_r != fbh_pkg::OEPH_CYC - 8'h01)
    |-> (cfg_r[fbh_pkg::CFG_CE_STB] ? (f_ce_n && !f_oe_n) : (f_oe_n && !f_ce_n)))
    else $error("poll strobe on wrong line");
  a_poll_settled: assert property (@(posedge hclk) disable iff (!hresetn) // [R15]
    ($rose(done_r) && have_prev_r && $past(state_r == fbh_pkg::ST_GAP) && poll_cmd_r)
    |-> rdata_r[fbh_pkg::GEN_TOG_BIT] == prev_samp_r[fbh_pkg::GEN_TOG_BIT] || !have_prev_r)
    else $error("poll ended while toggle bit still moving");
endmodule // fbh_ctrl

`default_nettype wire

/* File: verilog/fbh_pkg.sv */
// package: constants for the parallel flash bus host controller
package fbh_pkg;
  // ==========================================================
  // clock and pin timing
  localparam int CLK_PS      = 4000;
  localparam int T_WP_NS     = 30;   // write pulse low
  localparam int T_WPH_NS    = 30;   // write pulse high
  localparam int T_ACC_NS    = 70;   // access, also covers width switch
  localparam int T_OEPH_NS   = 20;   // strobe high between polls
  localparam int T_RP_NS     = 500;  // reset pulse width
  localparam int T_RH_NS     = 50;   // reset high before read
  localparam logic [7:0] WP_CYC   = 8'((T_WP_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [7:0] WPH_CYC  = 8'((T_WPH_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [7:0] ACC_CYC  = 8'((T_ACC_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [7:0] OEPH_CYC = 8'((T_OEPH_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [7:0] RP_CYC   = 8'((T_RP_NS * 1000 + CLK_PS - 1) / CLK_PS);
  localparam logic [7:0] RH_CYC   = 8'((T_RH_NS * 1000 + CLK_PS - 1) / CLK_PS);
  // ==========================================================
  // register map
  localparam logic [4:0] OFS_CMD    = 5'h00;
  localparam logic [4:0] OFS_CFG    = 5'h04;
  localparam logic [4:0] OFS_ADDR   = 5'h08;
  localparam logic [4:0] OFS_WDATA  = 5'h0c;
  localparam logic [4:0] OFS_RDATA  = 5'h10;
  localparam logic [4:0] OFS_STATUS = 5'h14;
  // command field
  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_POLL    = 2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ  = 2'h2;
  localparam logic [1:0] OP_RESET = 2'h3;
  // config fields
  localparam int CFG_WORD    = 0;
  localparam int CFG_CE_STB  = 1;
  localparam logic [1:0] CFG_RST = 2'h1;
  // status fields
  localparam int ST_BUSY     = 0;
  localparam int ST_DONE     = 1;
  localparam int ST_RB       = 2;
  // data bit position and bus widths
  localparam int GEN_TOG_BIT = 6;
  localparam int ADDR_W      = 22;
  localparam int DATA_W      = 16;
  // ==========================================================
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_WR   = 6'h02,
    ST_RD   = 6'h04,
    ST_RST  = 6'h08,
    ST_RREC = 6'h10,
    ST_GAP  = 6'h20
  } fbh_state_t;

  // word-aligned register match
  function automatic logic fbh_hit(input logic [31:0] a, input logic [4:0] ofs);
    return (a[31:5] == 27'h0000000) && (a[4:0] == ofs);
  endfunction
endpackage

/* File: tb/fbh_flash_model.sv */
// behavioural parallel flash device facing the host controller
`timescale 1ns/100ps
`default_nettype none
module fbh_flash_model #(
  parameter int PROG_NS = 6000
) (
  input  wire logic [21:0] f_addr,
  input  wire logic [15:0] f_dq_o,
  input  wire logic        f_dq_oe,
  input  wire logic        f_ce_n,
  input  wire logic        f_oe_n,
  input  wire logic        f_we_n,
  input  wire logic        f_reset_n,
  input  wire logic        f_word_n_byte,
  output wire logic [15:0] f_dq_i,
  output wire logic        ready_busy_flag
);
  localparam int STBY_NS = 35000;
  logic [15:0] mem [0:255];
  logic [15:0] pdata   = 16'h0000;
  logic [15:0] last    = 16'h0000;
  logic [15:0] w_d     = 16'h0000;
  logic [7:0]  w_a     = 8'h00;
  logic        w_ok    = 1'b0;
  logic        busy    = 1'b0;
  logic        tog     = 1'b0;
  logic        standby = 1'b0;
  time         due     = 0;
  time         rst_at  = 0;
  wire  logic  rd_act;
  wire  logic [15:0] val;
  initial foreach (mem[i]) mem[i] = 16'hffff;
  // ==========================================================
  // program and abort
  // strobes and data move on one host edge: look a little later
  always @(negedge f_we_n) begin
    #1;
    w_ok = !f_we_n && !f_ce_n && f_reset_n && f_dq_oe && !busy;
    w_a  = f_addr[7:0];
    w_d  = f_dq_o;
  end
  always @(posedge f_we_n) begin
    if (w_ok) begin
      mem[w_a] = w_d;
      pdata = w_d;
      busy = 1'b1;
      due = $time + PROG_NS;
    end
    w_ok = 1'b0;
  end
  // deadline timer, so an aborted run never swallows the next one
  always #1 begin
    if (busy && $time >= due)
      busy = 1'b0;
    standby = !f_reset_n && ($time - rst_at >= STBY_NS);
  end
  always @(negedge f_reset_n) begin
    busy = 1'b0;
    rst_at = $time;
  end
  // ==========================================================
  // read side; released lines show the inverse of the last value
  assign rd_act = !f_ce_n && !f_oe_n && f_reset_n;
  // no sector is erase-suspended, so the suspend bit holds still
  assign val = busy ? {pdata[15:8], ~pdata[7], tog, pdata[5:0]}
                    : mem[f_addr[7:0]];
  assign f_dq_i[7:0] = rd_act ? val[7:0] : ~last[7:0];
  assign f_dq_i[15:8] = (rd_act && f_word_n_byte) ? val[15:8] : ~last[15:8];
  always @(negedge rd_act) begin
    last = val;
    if (busy)
      tog = ~tog;
  end
  assign ready_busy_flag = ~busy;
endmodule // fbh_flash_model
`default_nettype wire

/* File: tb/flash_bus_status_reset_behaviour_tb_top.sv */
// testbench for the flash bus host controller
`timescale 1ns/100ps
`default_nettype none
module flash_bus_status_reset_behaviour_tb_top;
  localparam logic [31:0] A_CMD = 32'(fbh_pkg::OFS_CMD);
  localparam logic [31:0] A_CFG = 32'(fbh_pkg::OFS_CFG);
  localparam logic [31:0] A_ADR = 32'(fbh_pkg::OFS_ADDR);
  localparam logic [31:0] A_WD  = 32'(fbh_pkg::OFS_WDATA);
  localparam logic [31:0] A_RD  = 32'(fbh_pkg::OFS_RDATA);
  localparam logic [31:0] A_ST  = 32'(fbh_pkg::OFS_STATUS);
  logic        hclk = 1'b0;
  logic        hresetn, hsel, hwrite, hready, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [21:0] f_addr;
  logic [15:0] f_dq_i, f_dq_o;
  logic        f_dq_oe, f_ce_n, f_oe_n, f_we_n, f_reset_n, f_word_n_byte, rb;
  int          bad_count = 0;
  int          tests_run = 0;

  always #2 hclk = ~hclk;

  fbh_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .f_addr(f_addr), .f_dq_i(f_dq_i), .f_dq_o(f_dq_o),
    .f_dq_oe(f_dq_oe), .f_ce_n(f_ce_n), .f_oe_n(f_oe_n), .f_we_n(f_we_n),
    .f_reset_n(f_reset_n), .f_word_n_byte(f_word_n_byte), .ready_busy_flag(rb));
  fbh_flash_model flash (.f_addr(f_addr), .f_dq_o(f_dq_o), .f_dq_oe(f_dq_oe), .f_ce_n(f_ce_n),
    .f_oe_n(f_oe_n), .f_we_n(f_we_n), .f_reset_n(f_reset_n), .f_word_n_byte(f_word_n_byte),
    .f_dq_i(f_dq_i), .ready_busy_flag(rb));

  // ==========================================================
  // common tasks
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) begin
      bad_count++;
      finish_test();
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  // command, then status polled until done
  task automatic run_cmd(input logic [31:0] c);
    int n;
    n = 0;
    ahb(1'b1, A_CMD, c);
    do begin
      ahb(1'b0, A_ST, 32'h0);
      n++;
    end while (rd[1] !== 1'b1 && n < 3000);
    if (rd[1] !== 1'b1) begin
      bad_count++;
      finish_test();
    end
  endtask

  // ==========================================================
  // scenarios
  task automatic sc_idle;
    check("pins", {f_ce_n, f_oe_n, f_we_n, f_reset_n, f_dq_oe, f_word_n_byte}, 32'h3d);
    ahb(1'b0, A_CFG, 32'h0);
    check("cfg", rd, 32'h1);
    check("hresp", hresp, 1'b0);
    ahb(1'b0, 32'h40, 32'h0);
    check("unmapped", rd, 32'h0);
    ahb(1'b1, 32'h40, 32'h3);
    ahb(1'b0, A_ST, 32'h0);
    check("unmapped write", rd[1:0], 2'h0);
  endtask
  task automatic sc_prog(input logic ce, input logic [15:0] a, input logic [15:0] d);
    logic t0;
    logic t2;
    ahb(1'b1, A_CFG, {30'h0, ce, 1'b1});
    ahb(1'b1, A_ADR, {16'h0, a});
    ahb(1'b1, A_WD, {16'h0, d});
    run_cmd(32'h1);
    ahb(1'b0, A_ST, 32'h0);
    check("rb busy", rd[2], 1'b0);
    run_cmd(32'h2);
    ahb(1'b0, A_RD, 32'h0);
    check("poll bit", rd[7], !d[7]);
    t0 = rd[6];
    t2 = rd[2];
    ahb(1'b1, A_ADR, {16'h0, a ^ 16'h0001});
    run_cmd(32'h2);
    ahb(1'b0, A_RD, 32'h0);
    check("toggle", rd[6], !t0);
    check("suspend bit", rd[2], t2);
    ahb(1'b1, A_ADR, {16'h0, a});
    run_cmd(32'h6);
    ahb(1'b0, A_RD, 32'h0);
    check("array data", rd[15:0], d);
    ahb(1'b0, A_ST, 32'h0);
    check("rb ready", rd[2], 1'b1);
    run_cmd(32'h2);
    ahb(1'b0, A_RD, 32'h0);
    check("settled", rd[15:0], d);
  endtask
  task automatic sc_reset;
    ahb(1'b1, A_WD, 32'h1234);
    run_cmd(32'h1);
    ahb(1'b0, A_ST, 32'h0);
    check("write after read", rd[2], 1'b0);
    run_cmd(32'h3);
    check("reset pin", f_reset_n, 1'b1);
    check("standby", flash.standby, 1'b0);
    ahb(1'b0, A_ST, 32'h0);
    check("abort", rd[2], 1'b1);
    run_cmd(32'h1);
    ahb(1'b0, A_ST, 32'h0);
    check("write when ready", rd[2], 1'b0);
    run_cmd(32'h6);
    run_cmd(32'h3);
    run_cmd(32'h2);
    ahb(1'b0, A_RD, 32'h0);
    check("idle reset read", rd[15:0], 16'h1234);
  endtask
  task automatic sc_width;
    ahb(1'b1, A_CFG, 32'h0);
    repeat (2) @(posedge hclk);
    check("byte pin", f_word_n_byte, 1'b0);
    run_cmd(32'h2);
    ahb(1'b0, A_RD, 32'h0);
    check("byte data", rd[7:0], 8'h34);
    ahb(1'b1, A_CFG, 32'h1);
    repeat (2) @(posedge hclk);
    check("word pin", f_word_n_byte, 1'b1);
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    sc_idle();
    sc_prog(1'b0, 16'h0010, 16'h5a81);
    sc_prog(1'b1, 16'h0020, 16'h3c42);
    sc_reset();
    sc_width();
    finish_test();
  end
endmodule // flash_bus_status_reset_behaviour_tb_top
`default_nettype wire
